// ==== tap_pkg.sv ====
// Shared constants, states and decode helpers of the test access port
package tap_pkg;

    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int BSR_LEN_DEF = 8;
    localparam int PIN_W = 4;

    // Instruction codes
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_INTEST = 4'h1;
    localparam logic [3:0] INS_SAMPLE = 4'h2;
    localparam logic [3:0] INS_ABORT = 4'h8;
    localparam logic [3:0] INS_DPACC = 4'ha;
    localparam logic [3:0] INS_APACC = 4'hb;
    localparam logic [3:0] INS_IDCODE = 4'he;
    localparam logic [3:0] INS_BYPASS = 4'hf;

    // Reset and capture values
    localparam logic [3:0] IR_RESET = INS_IDCODE;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic BYP_CAPTURE = 1'b0;
    // Arbitrary identification value; bit 0 set as boundary-scan requires
    localparam logic [31:0] IDCODE_DEF = 32'h0000_1001;
    localparam logic [3:0] PIN_SEL_RESET = 4'hf;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR,
        TS_PAUSE_DR, TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR,
        TS_SHIFT_IR, TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
    } tap_state_t;

    // Unimplemented codes fall back to bypass
    function automatic logic [3:0] ins_decode(input logic [3:0] code);
        case (code)
            INS_EXTEST, INS_INTEST, INS_SAMPLE, INS_ABORT,
            INS_DPACC, INS_APACC, INS_IDCODE: ins_decode = code;
            default: ins_decode = INS_BYPASS;
        endcase
    endfunction

    // Instructions served by the core debug port
    function automatic logic ins_is_core(input logic [3:0] code);
        ins_is_core = (code == INS_APACC) || (code == INS_DPACC) ||
                      (code == INS_ABORT);
    endfunction

    // Instructions that act on held chain data only
    function automatic logic ins_is_hold(input logic [3:0] code);
        ins_is_hold = (code == INS_EXTEST) || (code == INS_INTEST);
    endfunction

endpackage

// ==== bit_sync.sv ====
// Two-stage synchroniser for independent level bits
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rst,
    // Level in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = rst ? '0 : d;
        nxt_sync = rst ? '0 : meta_ff;
    end

    always_ff @(posedge clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign q = sync_ff;
endmodule

// ==== tap_fsm.sv ====
// Test access port state machine stepped by TMS on rising TCK
`timescale 1ns/10ps
module tap_fsm (
    // Link clock and reset
    input  wire logic        tck,
    input  wire logic        rst,
    // Mode select
    input  wire logic        tms,
    // Current state
    output tap_pkg::tap_state_t state
);
    tap_pkg::tap_state_t state_ff;
    tap_pkg::tap_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tap_pkg::TS_RESET:    nxt_state = tms ? tap_pkg::TS_RESET : tap_pkg::TS_IDLE;
            tap_pkg::TS_IDLE:     nxt_state = tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
            tap_pkg::TS_SEL_DR:   nxt_state = tms ? tap_pkg::TS_SEL_IR : tap_pkg::TS_CAP_DR;
            tap_pkg::TS_CAP_DR:   nxt_state = tms ? tap_pkg::TS_EXIT1_DR : tap_pkg::TS_SHIFT_DR;
            tap_pkg::TS_SHIFT_DR: nxt_state = tms ? tap_pkg::TS_EXIT1_DR : tap_pkg::TS_SHIFT_DR;
            tap_pkg::TS_EXIT1_DR: nxt_state = tms ? tap_pkg::TS_UPD_DR : tap_pkg::TS_PAUSE_DR;
            tap_pkg::TS_PAUSE_DR: nxt_state = tms ? tap_pkg::TS_EXIT2_DR : tap_pkg::TS_PAUSE_DR;
            tap_pkg::TS_EXIT2_DR: nxt_state = tms ? tap_pkg::TS_UPD_DR : tap_pkg::TS_SHIFT_DR;
            tap_pkg::TS_UPD_DR:   nxt_state = tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
            // Third high TMS from idle leaves the scan columns here, for reset
            tap_pkg::TS_SEL_IR:   nxt_state = tms ? tap_pkg::TS_RESET : tap_pkg::TS_CAP_IR;
            tap_pkg::TS_CAP_IR:   nxt_state = tms ? tap_pkg::TS_EXIT1_IR : tap_pkg::TS_SHIFT_IR;
            tap_pkg::TS_SHIFT_IR: nxt_state = tms ? tap_pkg::TS_EXIT1_IR : tap_pkg::TS_SHIFT_IR;
            tap_pkg::TS_EXIT1_IR: nxt_state = tms ? tap_pkg::TS_UPD_IR : tap_pkg::TS_PAUSE_IR;
            tap_pkg::TS_PAUSE_IR: nxt_state = tms ? tap_pkg::TS_EXIT2_IR : tap_pkg::TS_PAUSE_IR;
            tap_pkg::TS_EXIT2_IR: nxt_state = tms ? tap_pkg::TS_UPD_IR : tap_pkg::TS_SHIFT_IR;
            tap_pkg::TS_UPD_IR:   nxt_state = tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
            default:              nxt_state = tap_pkg::TS_RESET;
        endcase
        if (rst) begin
            nxt_state = tap_pkg::TS_RESET;
        end
    end

    always_ff @(posedge tck) begin
        state_ff <= nxt_state;
    end

    assign state = state_ff;
endmodule

// ==== jtag_tap_debug_port.sv ====
// Test access port with vendor chains and core debug output multiplexer
`timescale 1ns/10ps
module jtag_tap_debug_port #(
    parameter int          BSR_LEN    = tap_pkg::BSR_LEN_DEF,
    parameter logic [31:0] IDCODE_VAL = tap_pkg::IDCODE_DEF
) (
    // System clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Test link
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    output logic                          tdo_o,
    output logic                          tdo_oe,
    // Core debug port serial output
    input  wire logic                     core_tdo,
    input  wire logic                     core_tdo_oe,
    // Boundary cells
    input  wire logic [BSR_LEN-1:0]       bsr_pin_in,
    output logic      [BSR_LEN-1:0]       bsr_pin_out,
    output logic                          bsr_drive_en,
    // Shared pin function select
    input  wire logic                     pin_sel_wr,
    input  wire logic [tap_pkg::PIN_W-1:0] pin_sel_wdata,
    input  wire logic [tap_pkg::PIN_W-1:0] commit_mask,
    input  wire logic                     commit_unlocked,
    output logic      [tap_pkg::PIN_W-1:0] pin_debug_sel,
    // Test modes seen by the system
    output logic                          extest_sys,
    output logic                          intest_sys
);
    // ---------------- Reset into the link domain ----------------
    // Reaches the link logic only while TCK runs
    logic tck_rst;

    bit_sync #(
        .WIDTH (1)
    ) u_rst_sync (
        .clk (tck),
        .rst (1'b0),
        .d   (rst),
        .q   (tck_rst)
    );

    // ---------------- State machine ----------------
    tap_pkg::tap_state_t st;

    tap_fsm u_fsm (
        .tck   (tck),
        .rst   (tck_rst),
        .tms   (tms),
        .state (st)
    );

    // ---------------- Boundary pin sampling ----------------
    logic [BSR_LEN-1:0] bsr_in_s;

    bit_sync #(
        .WIDTH (BSR_LEN)
    ) u_bsr_sync (
        .clk (tck),
        .rst (tck_rst),
        .d   (bsr_pin_in),
        .q   (bsr_in_s)
    );

    // ---------------- Instruction register ----------------
    logic [tap_pkg::IR_W-1:0] ir_shift_ff;
    logic [tap_pkg::IR_W-1:0] ir_ff;
    logic [tap_pkg::IR_W-1:0] nxt_ir_shift;
    logic [tap_pkg::IR_W-1:0] nxt_ir;
    logic [tap_pkg::IR_W-1:0] act;
    logic                     core_sel;
    logic                     hold;
    logic                     in_reset;

    always_comb begin
        in_reset = tck_rst || (st == tap_pkg::TS_RESET);
        act = tap_pkg::ins_decode(ir_ff);
        core_sel = tap_pkg::ins_is_core(act);
        hold = tap_pkg::ins_is_hold(act);
    end

    always_comb begin
        nxt_ir_shift = ir_shift_ff;
        nxt_ir = ir_ff;
        case (st)
            tap_pkg::TS_CAP_IR: begin
                nxt_ir_shift = tap_pkg::IR_CAPTURE;
            end
            tap_pkg::TS_SHIFT_IR: begin
                nxt_ir_shift = {tdi, ir_shift_ff[tap_pkg::IR_W-1:1]};
            end
            tap_pkg::TS_UPD_IR: begin
                nxt_ir = ir_shift_ff;
            end
            default: begin
                nxt_ir = ir_ff;
            end
        endcase
        if (in_reset) begin
            nxt_ir_shift = tap_pkg::IR_CAPTURE;
            nxt_ir = tap_pkg::IR_RESET;
        end
    end

    // No other clock reaches these, so a stopped TCK holds them
    always_ff @(posedge tck) begin
        ir_shift_ff <= nxt_ir_shift;
        ir_ff <= nxt_ir;
    end

    // ---------------- Data chains ----------------
    logic                      byp_ff;
    logic [tap_pkg::ID_W-1:0]  id_ff;
    logic [BSR_LEN-1:0]        bsr_shift_ff;
    logic [BSR_LEN-1:0]        bsr_upd_ff;
    logic                      nxt_byp;
    logic [tap_pkg::ID_W-1:0]  nxt_id;
    logic [BSR_LEN-1:0]        nxt_bsr_shift;
    logic [BSR_LEN-1:0]        nxt_bsr_upd;
    logic                      vendor_dr;
    logic [BSR_LEN:0]          bsr_cat;

    always_comb begin
        nxt_byp = byp_ff;
        nxt_id = id_ff;
        nxt_bsr_shift = bsr_shift_ff;
        nxt_bsr_upd = bsr_upd_ff;
        // One slice serves every chain length, a single cell included
        bsr_cat = {tdi, bsr_shift_ff};
        // Held-data modes and core instructions leave vendor chains alone
        vendor_dr = !hold && !core_sel;
        case (st)
            tap_pkg::TS_CAP_DR: begin
                if (vendor_dr) begin
                    case (act)
                        tap_pkg::INS_IDCODE: nxt_id = IDCODE_VAL;
                        tap_pkg::INS_SAMPLE: nxt_bsr_shift = bsr_in_s;
                        default:             nxt_byp = tap_pkg::BYP_CAPTURE;
                    endcase
                end
            end
            tap_pkg::TS_SHIFT_DR: begin
                if (vendor_dr) begin
                    case (act)
                        tap_pkg::INS_IDCODE: nxt_id = {tdi, id_ff[tap_pkg::ID_W-1:1]};
                        tap_pkg::INS_SAMPLE: begin
                            nxt_bsr_shift = bsr_cat[BSR_LEN:1];
                        end
                        default:             nxt_byp = tdi;
                    endcase
                end
            end
            tap_pkg::TS_UPD_DR: begin
                if (vendor_dr && act == tap_pkg::INS_SAMPLE) begin
                    nxt_bsr_upd = bsr_shift_ff;
                end
            end
            default: begin
                nxt_byp = byp_ff;
            end
        endcase
        if (in_reset) begin
            nxt_byp = tap_pkg::BYP_CAPTURE;
            nxt_id = IDCODE_VAL;
            nxt_bsr_shift = '0;
            nxt_bsr_upd = '0;
        end
    end

    always_ff @(posedge tck) begin
        byp_ff <= nxt_byp;
        id_ff <= nxt_id;
        bsr_shift_ff <= nxt_bsr_shift;
        bsr_upd_ff <= nxt_bsr_upd;
    end

    // Held boundary data drives the cells in extest and intest
    assign bsr_pin_out = bsr_upd_ff;
    assign bsr_drive_en = hold;

    // ---------------- Serial output ----------------
    logic ser_bit;
    logic ser_en;
    logic tdo_ff;
    logic oe_ff;
    logic nxt_tdo;
    logic nxt_oe;

    always_comb begin
        ser_bit = byp_ff;
        ser_en = 1'b0;
        if (st == tap_pkg::TS_SHIFT_IR) begin
            ser_bit = ir_shift_ff[0];
            ser_en = 1'b1;
        end else if (st == tap_pkg::TS_SHIFT_DR && vendor_dr) begin
            ser_en = 1'b1;
            case (act)
                tap_pkg::INS_IDCODE: ser_bit = id_ff[0];
                tap_pkg::INS_SAMPLE: ser_bit = bsr_shift_ff[0];
                default:             ser_bit = byp_ff;
            endcase
        end
        nxt_tdo = ser_bit;
        nxt_oe = ser_en && !in_reset;
    end

    always_ff @(negedge tck) begin
        tdo_ff <= nxt_tdo;
        oe_ff <= nxt_oe;
    end

    // Core instructions hand the pin to the core debug port
    assign tdo_o = core_sel ? core_tdo : tdo_ff;
    assign tdo_oe = core_sel ? core_tdo_oe : oe_ff;

    // ---------------- Test modes to system domain ----------------
    logic [1:0] mode_tck;
    logic [1:0] mode_sys;
    logic [1:0] mode_prev_ff;
    logic [1:0] mode_out_ff;
    logic [1:0] nxt_mode_prev;
    logic [1:0] nxt_mode_out;

    assign mode_tck = {act == tap_pkg::INS_INTEST, act == tap_pkg::INS_EXTEST};

    bit_sync #(
        .WIDTH (2)
    ) u_mode_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (mode_tck),
        .q   (mode_sys)
    );

    // Both bits can flip in one update; a code is passed on only
    // after two equal samples, so a skewed mix never reaches the system
    always_comb begin
        nxt_mode_prev = mode_sys;
        nxt_mode_out = mode_out_ff;
        if (mode_sys == mode_prev_ff) begin
            nxt_mode_out = mode_sys;
        end
        if (rst) begin
            nxt_mode_prev = '0;
            nxt_mode_out = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        mode_prev_ff <= nxt_mode_prev;
        mode_out_ff <= nxt_mode_out;
    end

    assign extest_sys = mode_out_ff[0];
    assign intest_sys = mode_out_ff[1];

    // ---------------- Shared pin function select ----------------
    logic [tap_pkg::PIN_W-1:0] pin_sel_ff;
    logic [tap_pkg::PIN_W-1:0] nxt_pin_sel;
    logic [tap_pkg::PIN_W-1:0] wr_mask;

    always_comb begin
        // Only unlocked, committed bits may change
        wr_mask = commit_unlocked ? commit_mask : '0;
        nxt_pin_sel = pin_sel_ff;
        if (pin_sel_wr) begin
            nxt_pin_sel = (pin_sel_ff & ~wr_mask) | (pin_sel_wdata & wr_mask);
        end
        if (rst) begin
            nxt_pin_sel = tap_pkg::PIN_SEL_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        pin_sel_ff <= nxt_pin_sel;
    end

    assign pin_debug_sel = pin_sel_ff;
endmodule

// ==== jtag_tap_debug_port_assertions.sv ====
// Concurrent checks on the test access port top-level ports
`timescale 1ns/10ps
module jtag_tap_debug_port_chk #(
    parameter int BSR_LEN = 8
) (
    // Clocks and reset
    input wire logic                      sys_clk,
    input wire logic                      rst,
    input wire logic                      tck,
    // Link
    input wire logic                      tms,
    input wire logic                      tdo_oe,
    // Boundary cells and modes
    input wire logic [BSR_LEN-1:0]        bsr_pin_out,
    input wire logic                      bsr_drive_en,
    input wire logic                      extest_sys,
    input wire logic                      intest_sys,
    // Pin select
    input wire logic                      pin_sel_wr,
    input wire logic [tap_pkg::PIN_W-1:0] pin_sel_wdata,
    input wire logic [tap_pkg::PIN_W-1:0] commit_mask,
    input wire logic                      commit_unlocked,
    input wire logic [tap_pkg::PIN_W-1:0] pin_debug_sel
);
    // Run length of TMS high, saturating
    logic [2:0] high_cnt_ff;
    logic [2:0] nxt_high_cnt;

    always_comb begin
        nxt_high_cnt = 3'h0;
        if (!rst && tms) begin
            nxt_high_cnt = (high_cnt_ff == 3'h7) ? 3'h7 : high_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge tck) begin
        high_cnt_ff <= nxt_high_cnt;
    end

    chk_tlr_ir_default: assert property (@(posedge tck) disable iff (rst)
        (high_cnt_ff >= 3'h6) |-> !bsr_drive_en) else $error("mode not cleared by reset run");
    chk_tlr_bsr_clear: assert property (@(posedge tck) disable iff (rst)
        (high_cnt_ff >= 3'h6) |-> (bsr_pin_out == '0)) else $error("boundary not cleared");
    chk_tlr_tdo_off: assert property (@(negedge tck) disable iff (rst)
        (high_cnt_ff >= 3'h6) |-> !tdo_oe) else $error("tdo driven in reset state");
    chk_hold_bsr_stable: assert property (@(posedge tck) disable iff (rst)
        (bsr_drive_en && $past(bsr_drive_en)) |-> $stable(bsr_pin_out))
        else $error("boundary changed in hold mode");
    chk_mode_rise_cross: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(bsr_drive_en) |-> ##[1:4] (extest_sys || intest_sys)) else $error("mode late");
    chk_mode_fall_cross: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(bsr_drive_en) |-> ##[1:4] !(extest_sys || intest_sys)) else $error("mode stuck");
    chk_pin_commit_write: assert property (@(posedge sys_clk) disable iff (rst)
        (pin_sel_wr && commit_unlocked) |=> pin_debug_sel == (($past(pin_sel_wdata)
        & $past(commit_mask)) | ($past(pin_debug_sel) & ~$past(commit_mask))))
        else $error("pin select write wrong");
    chk_pin_locked_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !(pin_sel_wr && commit_unlocked) |=> $stable(pin_debug_sel))
        else $error("pin select changed while locked");
    chk_pin_reset_val: assert property (@(posedge sys_clk)
        rst |=> (pin_debug_sel == tap_pkg::PIN_SEL_RESET)) else $error("pin select reset");
endmodule

bind jtag_tap_debug_port jtag_tap_debug_port_chk #(.BSR_LEN(BSR_LEN)) chk_u (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdo_oe(tdo_oe),
    .bsr_pin_out(bsr_pin_out), .bsr_drive_en(bsr_drive_en), .extest_sys(extest_sys),
    .intest_sys(intest_sys), .pin_sel_wr(pin_sel_wr), .pin_sel_wdata(pin_sel_wdata),
    .commit_mask(commit_mask), .commit_unlocked(commit_unlocked),
    .pin_debug_sel(pin_debug_sel)
);

// ==== tap_probe.sv ====
// Boundary-scan tester model driving the test link
`timescale 1ns/10ps
module tap_probe (
    // Link driven by the tester
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Device output pin
    input  wire logic tdo_o,
    input  wire logic tdo_oe
);
    // Pull-up holds a released output high
    wire tdo_w;
    assign tdo_w = tdo_oe ? tdo_o : 1'b1;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One link cycle of 160 ns; clock rests low between calls
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        #1;
        tms = tms_v;
        tdi = tdi_v;
        #79;
        tdo_v = tdo_w;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask
endmodule

// ==== jtag_tap_debug_port_tb_top.sv ====
// Self-checking bench of the test access port
`timescale 1ns/10ps
module jtag_tap_debug_port_tb_top;
    localparam int          BL  = 8;
    localparam logic [31:0] IDV = 32'h0000_5a01; // Arbitrary identification value
    logic          sys_clk, rst, tck, tms, tdi, tdo_o, tdo_oe, core_tdo, core_tdo_oe;
    logic [BL-1:0] bsr_pin_in, bsr_pin_out;
    logic          bsr_drive_en, pin_sel_wr, commit_unlocked, extest_sys, intest_sys;
    logic [3:0]    pin_sel_wdata, commit_mask, pin_debug_sel;
    logic [31:0]   got;
    int            bad_count, compares, cycles;

    jtag_tap_debug_port #(.BSR_LEN(BL), .IDCODE_VAL(IDV)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .tdo_oe(tdo_oe), .core_tdo(core_tdo), .core_tdo_oe(core_tdo_oe),
        .bsr_pin_in(bsr_pin_in), .bsr_pin_out(bsr_pin_out), .bsr_drive_en(bsr_drive_en),
        .pin_sel_wr(pin_sel_wr), .pin_sel_wdata(pin_sel_wdata), .commit_mask(commit_mask),
        .commit_unlocked(commit_unlocked), .pin_debug_sel(pin_debug_sel),
        .extest_sys(extest_sys), .intest_sys(intest_sys));
    tap_probe probe_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // From idle: walk to a shift state, move n bits LSB first, update, back to idle
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic b;
        dout = '0;
        probe_u.step(1'b1, 1'b0, b);
        if (ir)
            probe_u.step(1'b1, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            probe_u.step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        probe_u.step(1'b1, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
    endtask

    task automatic tap_reset();
        logic b;
        repeat (6) probe_u.step(1'b1, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
    endtask

    task automatic t_idcode();
        shift(1'b0, 32, 32'h0, got);
        check(got, IDV);
        shift(1'b1, 4, tap_pkg::INS_IDCODE, got);
        check(got, tap_pkg::IR_CAPTURE);
        #1 check(tdo_oe, 1'b0);
    endtask

    task automatic t_bypass();
        logic [3:0] codes [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, 4'hf};
        foreach (codes[k]) begin
            shift(1'b1, 4, codes[k], got);
            shift(1'b0, 2, 32'h3, got);
            check(got, 32'h2);
            #1 check(tdo_oe, 1'b0);
        end
    endtask

    task automatic t_sample();
        shift(1'b1, 4, tap_pkg::INS_SAMPLE, got);
        check(bsr_drive_en, 1'b0);
        shift(1'b0, BL, 32'h3c, got);
        check(got, 32'ha5);
        check(bsr_pin_out, 32'h3c);
        #4000;
        check(bsr_pin_out, 32'h3c);
        shift(1'b0, BL, 32'h3c, got);
        check(got, 32'ha5);
    endtask

    task automatic t_hold();
        logic [3:0] codes [2] = '{tap_pkg::INS_EXTEST, tap_pkg::INS_INTEST};
        foreach (codes[k]) begin
            shift(1'b1, 4, codes[k], got);
            check(bsr_drive_en, 1'b1);
            repeat (5) @(posedge sys_clk);
            check({extest_sys, intest_sys}, (k == 0) ? 2'b10 : 2'b01);
            shift(1'b0, BL, 32'h0, got);
            check(got, 32'hff);
            check(bsr_pin_out, 32'h3c);
        end
    endtask

    task automatic t_tlr();
        logic b;
        probe_u.step(1'b1, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
        repeat (5) probe_u.step(1'b1, 1'b0, b);
        probe_u.step(1'b0, 1'b0, b);
        check(bsr_drive_en, 1'b0);
        check(bsr_pin_out, 32'h0);
        shift(1'b0, 32, 32'h0, got);
        check(got, IDV);
    endtask

    task automatic t_core();
        logic [3:0] codes [3] = '{tap_pkg::INS_APACC, tap_pkg::INS_DPACC, tap_pkg::INS_ABORT};
        foreach (codes[k]) begin
            shift(1'b1, 4, codes[k], got);
            #1 core_tdo_oe = 1'b1;
            core_tdo = 1'b1;
            #1 check({tdo_oe, tdo_o}, 2'b11);
            core_tdo = 1'b0;
            #1 check({tdo_oe, tdo_o}, 2'b10);
            core_tdo_oe = 1'b0;
            #1 check(tdo_oe, 1'b0);
        end
        tap_reset();
        #1 check(tdo_oe, 1'b0);
    endtask

    task automatic pin_wr(input logic u, input logic [3:0] m, input logic [3:0] d,
                          input logic [3:0] e);
        @(posedge sys_clk);
        #1 pin_sel_wr = 1'b1;
        commit_unlocked = u;
        commit_mask = m;
        pin_sel_wdata = d;
        @(posedge sys_clk);
        #1 pin_sel_wr = 1'b0;
        check(pin_debug_sel, e);
    endtask

    initial begin
        logic b;
        rst = 1'b1;
        pin_sel_wr = 1'b0;
        pin_sel_wdata = 4'h0;
        commit_mask = 4'h0;
        commit_unlocked = 1'b0;
        core_tdo = 1'b0;
        core_tdo_oe = 1'b0;
        bsr_pin_in = 8'ha5;
        fork
            begin
                repeat (12) @(posedge sys_clk);
                #1 rst = 1'b0;
            end
            begin
                #17;
                repeat (3) probe_u.step(1'b1, 1'b0, b);
            end
        join
        check(pin_debug_sel, tap_pkg::PIN_SEL_RESET);
        #1 check(tdo_oe, 1'b0);
        tap_reset();
        t_idcode();
        t_bypass();
        t_sample();
        t_hold();
        t_tlr();
        t_core();
        pin_wr(1'b0, 4'hf, 4'h0, 4'hf);
        pin_wr(1'b1, 4'h1, 4'h0, 4'he);
        pin_wr(1'b1, 4'hf, 4'h5, 4'h5);
        complete_run();
    end
endmodule
